// ### verilog/pioc_pkg.sv
package pioc_pkg;

	// Register addresses in the I/O control space
	localparam logic [7:0] PIOC_ADDR_DIRECTION   = 8'hf6;
	localparam logic [7:0] PIOC_ADDR_CHANGE_EN   = 8'hf9;
	localparam logic [7:0] PIOC_ADDR_PRESCALER   = 8'hfa;
	localparam logic [7:0] PIOC_ADDR_PULL_DOWN   = 8'hfb;
	localparam logic [7:0] PIOC_ADDR_OPEN_DRAIN  = 8'hfc;
	localparam logic [7:0] PIOC_ADDR_PULL_HIGH   = 8'hfd;
	localparam logic [7:0] PIOC_ADDR_SYS_CTRL    = 8'hfe;

	// Reset values
	localparam logic [7:0] PIOC_RST_DIRECTION    = 8'hff;
	localparam logic [7:0] PIOC_RST_CHANGE_EN    = 8'hff;
	localparam logic [7:0] PIOC_RST_PULL_DOWN    = 8'hff;
	localparam logic [7:0] PIOC_RST_OPEN_DRAIN   = 8'h00;
	localparam logic [7:0] PIOC_RST_PULL_HIGH    = 8'hff;
	localparam logic [7:0] PIOC_RST_SYS_CTRL     = 8'ha0;
	localparam logic [7:0] PIOC_RST_PORT_LATCH   = 8'h00;

	// Implemented bit masks
	localparam logic [7:0] PIOC_MASK_ALL         = 8'hff;
	localparam logic [7:0] PIOC_MASK_SYS_CTRL    = 8'hec;
	localparam logic [7:0] PIOC_MASK_OD_PINS     = 8'hf7;
	localparam logic [7:0] PIOC_MASK_PH_PINS     = 8'h17;
	localparam logic [7:0] PIOC_ZERO             = 8'h00;

	// System control field positions
	localparam int PIOC_SC_CONST_SINK            = 2;
	localparam int PIOC_SC_LOW_POWER_RST         = 3;
	localparam int PIOC_SC_LOW_VOLT_RST          = 5;
	localparam int PIOC_SC_EXT_IRQ_SEL           = 6;
	localparam int PIOC_SC_WATCHDOG              = 7;

	// Pin numbers with special roles
	localparam int PIOC_PIN_EXT_IRQ              = 0;
	localparam int PIOC_PIN_SINK                 = 1;

	// Per-pin analog controls handed to the pad ring
	typedef struct packed {
		logic [7:0] drive_en;    // Output driver enabled
		logic [7:0] drive_val;   // Level driven
		logic [7:0] pullup_en;   // Pull-high active
		logic [7:0] pulldown_en; // Pull-down active
		logic [7:0] opendrain;   // Open-drain mode
		logic       const_sink;  // Constant sink on pin 1
	} pioc_pad_ctrl_t;

	// System functions enabled by software
	typedef struct packed {
		logic watchdog_enable;
		logic low_voltage_reset_enable;
		logic low_power_reset_enable;
		logic ext_irq_pin_select;
	} pioc_sys_en_t;

endpackage

// ### verilog/pioc_change_detect.sv
`timescale 1ns/1ps
`default_nettype none

// Samples the pins and reports changes on enabled pins
module pioc_change_detect
	import pioc_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pin_in,
	input  wire logic [WIDTH-1:0] change_en,
	output logic      [WIDTH-1:0] pin_level,
	output logic                  change_event
);

	logic [WIDTH-1:0] prev_level;   // Level one clock earlier
	logic [WIDTH-1:0] mismatch;     // Per-pin difference

	// Compare current sample against previous, enabled pins only
	assign mismatch     = (pin_level ^ prev_level) & change_en;
	assign change_event = |mismatch;

	// Sample and history registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_level  <= '0;
			prev_level <= '0;
		end else begin
			pin_level  <= pin_in;
			prev_level <= pin_level;
		end
	end

endmodule

`default_nettype wire

// ### verilog/pioc_port_ctrl.sv
// Operation
// - Direction bit one means input, zero output
// - Change-enable bit gates pin change interrupt
// - Prescaler view reads live shared counter
// - Pull-down active low, nibbles swapped
// - Open-drain bits enable open-drain drive
// - Bit 3 open-drain/pull-high is storage only
// - Pull-high active low on pins 0,1,2,4
// - Constant sink on pin 1 in output
// - System bit 3 enables low-power reset
// - System bit 5 enables low-voltage reset
// - Select bit makes pin 0 interrupt input
// - Select clear leaves pin 0 plain
// - System bit 7 enables the watchdog
// - System bits 0,1,4 unimplemented
// - All control registers read and write
// - Change sets sticky flag until cleared
// - Direction resets to all inputs
`timescale 1ns/1ps
`default_nettype none

module pioc_port_ctrl
	import pioc_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	// I/O control space access from the core
	input  wire logic             io_control_write_instr,
	input  wire logic             io_control_read_instr,
	input  wire logic [7:0]       io_addr,
	input  wire logic [7:0]       io_wdata,
	output logic      [7:0]       io_rdata,
	// Port data register access from the core
	input  wire logic             port_write,
	input  wire logic [WIDTH-1:0] port_wdata,
	output logic      [WIDTH-1:0] port_rdata,
	// Interrupt status flag for port changes
	input  wire logic             port_change_flag_clear,
	output logic                  port_change_flag,
	// Prescaler count from the timer block
	input  wire logic [7:0]       prescaler_count,
	// Pin side
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_out,
	output logic      [WIDTH-1:0] pin_oe,
	output pioc_pad_ctrl_t        pad_ctrl,
	// System enables and external interrupt level
	output pioc_sys_en_t          sys_en,
	output logic                  ext_irq_level
);

	// Merge write data into implemented bits only
	function automatic logic [7:0] pioc_merge(input logic [7:0] data, input logic [7:0] mask);
		pioc_merge = data & mask;
	endfunction

	// Swap the two nibbles of a byte
	function automatic logic [7:0] pioc_swap(input logic [7:0] v);
		pioc_swap = {v[3:0], v[7:4]};
	endfunction

	// Control registers
	logic [7:0]       port_direction;          // One bit per pin, 1 = input
	logic [7:0]       port_change_irq_enable;  // Change interrupt enables
	logic [7:0]       pull_down_control;       // Active low, nibble swapped
	logic [7:0]       open_drain_control;      // Open-drain enables plus storage bit
	logic [7:0]       pull_high_control;       // Active low on pins 0,1,2,4, bits 3,5,6,7 storage only
	logic [7:0]       system_control;          // System enables
	logic [WIDTH-1:0] port_latch;              // Output data latch

	// Decoded strobes
	wire wr_direction = io_control_write_instr && (io_addr == PIOC_ADDR_DIRECTION);
	wire wr_change_en = io_control_write_instr && (io_addr == PIOC_ADDR_CHANGE_EN);
	wire wr_pull_down = io_control_write_instr && (io_addr == PIOC_ADDR_PULL_DOWN);
	wire wr_open_drn  = io_control_write_instr && (io_addr == PIOC_ADDR_OPEN_DRAIN);
	wire wr_pull_high = io_control_write_instr && (io_addr == PIOC_ADDR_PULL_HIGH);
	wire wr_sys_ctrl  = io_control_write_instr && (io_addr == PIOC_ADDR_SYS_CTRL);

	// Sampled pin levels and change event
	logic [WIDTH-1:0] pin_level;
	logic             change_event;

	// Change detection on enabled pins
	pioc_change_detect #(
		.WIDTH       (WIDTH)
	) u_change (
		.core_clk    (core_clk),
		.rst_n       (rst_n),
		.pin_in      (pin_in),
		.change_en   (port_change_irq_enable[WIDTH-1:0]),
		.pin_level   (pin_level),
		.change_event(change_event)
	);

	// Effective direction: pin 0 held as input while interrupt selected
	wire              ext_sel   = system_control[PIOC_SC_EXT_IRQ_SEL];
	wire [WIDTH-1:0]  out_mode  = ~port_direction[WIDTH-1:0];
	wire [WIDTH-1:0]  ext_mask  = {{(WIDTH-1){1'b0}}, ext_sel};
	wire [WIDTH-1:0]  drive_sel = out_mode & ~ext_mask;
	wire [WIDTH-1:0]  od_pins   = open_drain_control[WIDTH-1:0] & PIOC_MASK_OD_PINS[WIDTH-1:0];

	// Open-drain pins only drive when the latch is low
	assign pin_out = port_latch;
	assign pin_oe  = drive_sel & ~(od_pins & port_latch);

	// Pad controls
	assign pad_ctrl.drive_en    = pin_oe;
	assign pad_ctrl.drive_val   = port_latch;
	assign pad_ctrl.opendrain   = od_pins;
	assign pad_ctrl.pullup_en   = ~pull_high_control & PIOC_MASK_PH_PINS;
	assign pad_ctrl.pulldown_en = ~pioc_swap(pull_down_control);
	assign pad_ctrl.const_sink  = system_control[PIOC_SC_CONST_SINK] && drive_sel[PIOC_PIN_SINK];

	// System enables
	assign sys_en.watchdog_enable          = system_control[PIOC_SC_WATCHDOG];
	assign sys_en.low_voltage_reset_enable = system_control[PIOC_SC_LOW_VOLT_RST];
	assign sys_en.low_power_reset_enable   = system_control[PIOC_SC_LOW_POWER_RST];
	assign sys_en.ext_irq_pin_select       = ext_sel;

	// External interrupt level from pin 0 only when selected
	assign ext_irq_level = ext_sel && pin_level[PIOC_PIN_EXT_IRQ];

	// Port data read: pin level for input-mode pins and for pin 0 while interrupt selected, latch otherwise
	assign port_rdata = (pin_level & ~drive_sel) | (port_latch & drive_sel);

	// Read multiplexer
	logic [7:0] next_rdata;
	always_comb begin
		case (io_addr)
			PIOC_ADDR_DIRECTION:  next_rdata = port_direction;
			PIOC_ADDR_CHANGE_EN:  next_rdata = port_change_irq_enable;
			PIOC_ADDR_PRESCALER:  next_rdata = prescaler_count;
			PIOC_ADDR_PULL_DOWN:  next_rdata = pull_down_control;
			PIOC_ADDR_OPEN_DRAIN: next_rdata = open_drain_control;
			PIOC_ADDR_PULL_HIGH:  next_rdata = pull_high_control;
			PIOC_ADDR_SYS_CTRL:   next_rdata = system_control;
			default:              next_rdata = PIOC_ZERO;
		endcase
	end

	// Read data register, updated on a read instruction
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata <= PIOC_ZERO;
		end else if (io_control_read_instr) begin
			io_rdata <= next_rdata;
		end
	end

	// Control register writes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_direction         <= PIOC_RST_DIRECTION;
			port_change_irq_enable <= PIOC_RST_CHANGE_EN;
			pull_down_control      <= PIOC_RST_PULL_DOWN;
			open_drain_control     <= PIOC_RST_OPEN_DRAIN;
			pull_high_control      <= PIOC_RST_PULL_HIGH;
			system_control         <= PIOC_RST_SYS_CTRL;
		end else begin
			if (wr_direction) port_direction <= pioc_merge(io_wdata, PIOC_MASK_ALL);
			if (wr_change_en) port_change_irq_enable <= pioc_merge(io_wdata, PIOC_MASK_ALL);
			if (wr_pull_down) pull_down_control <= pioc_merge(io_wdata, PIOC_MASK_ALL);
			if (wr_open_drn)  open_drain_control <= pioc_merge(io_wdata, PIOC_MASK_ALL);
			if (wr_pull_high) pull_high_control <= pioc_merge(io_wdata, PIOC_MASK_ALL);
			if (wr_sys_ctrl)  system_control <= pioc_merge(io_wdata, PIOC_MASK_SYS_CTRL);
		end
	end

	// Port output latch
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_latch <= PIOC_RST_PORT_LATCH[WIDTH-1:0];
		end else if (port_write) begin
			port_latch <= port_wdata;
		end
	end

	// Sticky change flag, a new event wins over a clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_change_flag <= 1'b0;
		end else if (change_event) begin
			port_change_flag <= 1'b1;
		end else if (port_change_flag_clear) begin
			port_change_flag <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ### tb/pioc_port_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the port control block
module pioc_port_ctrl_checker
	import pioc_pkg::*;
(
	input wire logic           core_clk,
	input wire logic           rst_n,
	input wire logic           io_control_write_instr,
	input wire logic           io_control_read_instr,
	input wire logic [7:0]     io_addr,
	input wire logic [7:0]     io_wdata,
	input wire logic [7:0]     io_rdata,
	input wire logic           port_change_flag_clear,
	input wire logic           port_change_flag,
	input wire logic [7:0]     prescaler_count,
	input wire logic [7:0]     pin_oe,
	input wire pioc_pad_ctrl_t pad_ctrl,
	input wire pioc_sys_en_t   sys_en,
	input wire logic           ext_irq_level
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire logic wr_dir = io_control_write_instr && io_addr == PIOC_ADDR_DIRECTION; // Direction write
	wire logic wr_sys = io_control_write_instr && io_addr == PIOC_ADDR_SYS_CTRL;  // System write
	logic [7:0] last_wdata; // Write data one cycle back
	always_ff @(posedge core_clk) last_wdata <= io_wdata;
	all_input_a: assert property (
		wr_dir && io_wdata == 8'hff |=> pin_oe == 8'h00) else $error("pin driven in input mode");
	prescale_view_a: assert property (
		io_control_read_instr && io_addr == PIOC_ADDR_PRESCALER |=> io_rdata == $past(prescaler_count))
		else $error("prescaler read wrong");
	read_hold_a: assert property (
		!io_control_read_instr |=> $stable(io_rdata)) else $error("read data moved");
	sys_bits_a: assert property (
		wr_sys |=> sys_en == {last_wdata[7], last_wdata[5], last_wdata[3], last_wdata[6]}) else $error("bad sys_en");
	ext_off_a: assert property (
		sys_en.ext_irq_pin_select |-> !pin_oe[0]) else $error("pin 0 driven as interrupt input");
	ext_quiet_a: assert property (
		!sys_en.ext_irq_pin_select ##1 !sys_en.ext_irq_pin_select |-> !ext_irq_level) else $error("stray irq level");
	flag_hold_a: assert property (
		port_change_flag && !port_change_flag_clear |=> port_change_flag) else $error("flag dropped");
	storage_bits_a: assert property (
		(pad_ctrl.pullup_en & ~PIOC_MASK_PH_PINS) == 8'h00 && !pad_ctrl.opendrain[3]) else $error("bit 3 drives pin");
	cover property (port_change_flag_clear && port_change_flag);
	cover property (wr_sys && io_wdata[6]);
	cover property (io_control_read_instr && io_addr == PIOC_ADDR_PRESCALER);
endmodule
bind pioc_port_ctrl pioc_port_ctrl_checker chk_i (.*);
`default_nettype wire

// ### tb/pioc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// Outside circuitry on the eight pins
module pioc_pin_model
	import pioc_pkg::*;
(
	input  wire logic           core_clk,
	input  wire pioc_pad_ctrl_t pad_ctrl,
	input  wire logic [7:0]     ext_en,
	input  wire logic [7:0]     ext_val,
	output logic      [7:0]     pin_in
);
	logic [7:0] wander = 8'h5a; // Level of an undriven pin, never steady
	always @(posedge core_clk) wander <= ~wander;
	// Device drive wins, then outside drive, then pulls
	always_comb for (int i = 0; i < 8; i++)
		pin_in[i] = pad_ctrl.drive_en[i] ? pad_ctrl.drive_val[i] : ext_en[i] ? ext_val[i] :
			pad_ctrl.pullup_en[i] | (~pad_ctrl.pulldown_en[i] & wander[i]);
endmodule
`default_nettype wire

// ### tb/pioc_port_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pioc_port_ctrl_tb_top
	import pioc_pkg::*;
;
	logic           core_clk, rst_n, io_control_write_instr, io_control_read_instr, port_write;
	logic           port_change_flag_clear, port_change_flag, ext_irq_level;
	logic [7:0]     io_addr, io_wdata, io_rdata, port_wdata, port_rdata, prescaler_count;
	logic [7:0]     pin_in, pin_out, pin_oe, ext_en, ext_val, lat, e, d;
	pioc_pad_ctrl_t pad_ctrl;
	pioc_sys_en_t   sys_en;
	int             num_errors, checks_done, i;
	logic [7:0]     mdl[int]; // Register model by address
	pioc_port_ctrl uut (.*);
	pioc_pin_model far (.core_clk(core_clk), .pad_ctrl(pad_ctrl), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// One comparison
	task automatic chk(input string n, input logic [7:0] x, input logic [7:0] s);
		checks_done++;
		if (s !== x) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask
	// One control space access; reads compared with the model
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		port_write <= 1'b0;
		io_addr <= a;
		io_wdata <= v;
		io_control_write_instr <= w;
		io_control_read_instr <= !w;
		prescaler_count <= 8'($urandom);
		@(posedge core_clk);
		io_control_write_instr <= 1'b0;
		io_control_read_instr <= 1'b0;
		#1;
		if (w && mdl.exists(a))
			mdl[a] = v & (a == 8'hfe ? 8'hec : 8'hff);
		else if (!w)
			chk("io_rdata", a == 8'hfa ? prescaler_count : mdl.exists(a) ? mdl[a] : 8'h00, io_rdata);
	endtask
	// Reset pulse, then all registers read back
	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		mdl = '{246: 8'hff, 249: 8'hff, 251: 8'hff, 252: 8'h00, 253: 8'hff, 254: 8'ha0};
		foreach (mdl[a]) acc(1'b0, 8'(a), 8'h00);
	endtask
	task automatic close_out();
		$display("checks_done %0d num_errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		{io_control_write_instr, io_control_read_instr, port_write, port_change_flag_clear} = 4'h0;
		{io_addr, io_wdata, port_wdata, prescaler_count, ext_val} = 40'h0;
		ext_en = 8'hff;
		num_errors = 0;
		checks_done = 0;
		void'($urandom(79));
		do_reset();
		// Random writes over the map, then pad and pin checks
		for (i = 0; i < 24; i++) begin
			ext_val <= 8'($urandom);
			lat = 8'($urandom);
			port_wdata <= lat;
			port_write <= 1'b1;
			acc(1'b1, 8'hf6 + 8'($urandom_range(8)), 8'($urandom));
			acc(1'b0, 8'hf6 + 8'($urandom_range(8)), 8'h00);
			e = ~mdl[246] & ~(mdl[252] & 8'hf7 & lat) & ~{7'h00, mdl[254][6]};
			chk("pin_oe", e, pin_oe);
			// Output-mode pins read back the latch, open-drain ones too; input-mode pins and pin 0 while interrupt selected read the pin
			d = ~mdl[246] & ~{7'h00, mdl[254][6]};
			chk("port_rdata", (d & lat) | (~d & ext_val), port_rdata);
			chk("pulldown_en", ~{mdl[251][3:0], mdl[251][7:4]}, pad_ctrl.pulldown_en);
			chk("pullup_en", ~mdl[253] & 8'h17, pad_ctrl.pullup_en);
			chk("opendrain", mdl[252] & 8'hf7, pad_ctrl.opendrain);
			chk("sys_en", {4'h0, mdl[254][7], mdl[254][5], mdl[254][3], mdl[254][6]}, 8'(sys_en));
			chk("const_sink", 8'(mdl[254][2] & ~mdl[246][1]), 8'(pad_ctrl.const_sink));
			chk("ext_irq_level", 8'(mdl[254][6] & ext_val[0]), 8'(ext_irq_level));
		end
		acc(1'b1, 8'hfe, 8'h00);
		acc(1'b1, 8'hf6, 8'hff);
		acc(1'b1, 8'hf9, 8'($urandom));
		// Toggle each pin once; flag follows its enable bit
		for (i = 0; i < 8; i++) begin
			port_change_flag_clear <= 1'b1;
			@(posedge core_clk);
			port_change_flag_clear <= 1'b0;
			ext_val <= ext_val ^ (8'h01 << i);
			@(posedge core_clk);
			#1;
			chk("flag_cleared", 8'h00, 8'(port_change_flag));
			@(posedge core_clk);
			#1;
			chk("flag_set", 8'(mdl[249][i]), 8'(port_change_flag));
		end
		do_reset();
		close_out();
	end
endmodule
`default_nettype wire
